// *** host_model.sv ***
`timescale 1ns/100ps
module host_model #(
    parameter int EXT_HALF = 5
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // host side
    input  wire logic want,
    output logic      hold_req_in,
    output logic      iface_clk_in
);
    int cnt;

    // host asks for the bus while it wants it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_req_in <= 1'b0;
        end else begin
            hold_req_in <= want;
        end
    end

    // external oscillator, EXT_HALF core cycles per half period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt          <= 0;
            iface_clk_in <= 1'b0;
        end else if (cnt == EXT_HALF - 1) begin
            cnt          <= 0;
            iface_clk_in <= ~iface_clk_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : host_model

// *** iface_clk_gen.sv ***
`timescale 1ns/100ps
module iface_clk_gen (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // configuration
    input  wire logic              run,
    input  wire nmp_pkg::clk_src_t src,
    input  wire nmp_pkg::ratio_t   ratio,
    input  wire logic              iface_clk_in,
    // results
    output logic                   tick,
    output logic                   full_clk_out,
    output logic                   div_clk_out
);
    import nmp_pkg::*;

    // core cycles per interface period for the two divided sources
    function automatic logic [2:0] div_period(input clk_src_t sel);
        return (sel == SRC_DIV4) ? DIV4_PERIOD : DIV6_PERIOD;
    endfunction : div_period

    logic [2:0] cnt, next_cnt;
    logic       ext_q, next_ext_q;
    logic [1:0] div_cnt, next_div_cnt;
    logic       next_tick, next_full, next_div;
    logic       rise, fall;

    // rise and fall events of the selected interface clock
    always_comb begin
        next_cnt   = cnt;
        next_ext_q = iface_clk_in;
        rise       = 1'b0;
        fall       = 1'b0;
        if (run) begin
            if (src == SRC_EXT) begin
                rise     = iface_clk_in & ~ext_q;
                fall     = ~iface_clk_in & ext_q;
                next_cnt = 3'h0;
            end else begin
                if (cnt == div_period(src) - 3'h1) begin
                    next_cnt = 3'h0;
                end else begin
                    next_cnt = cnt + 3'h1;
                end
                rise = (cnt == 3'h0);
                fall = (cnt == div_period(src) >> 1); // high for the first half period
            end
        end
    end

    // full-rate clock follows the selected clock; divided clock toggles per ratio
    always_comb begin
        next_tick    = rise;
        next_full    = full_clk_out;
        next_div     = div_clk_out;
        next_div_cnt = div_cnt;
        if (rise) begin
            next_full = 1'b1;
        end else if (fall) begin
            next_full = 1'b0;
        end
        case (ratio)
            RATIO_1: begin
                next_div = next_full;
            end
            RATIO_2: begin
                if (rise) begin
                    next_div = ~div_clk_out;
                end
            end
            default: begin
                if (rise) begin
                    next_div_cnt = div_cnt + 2'h1;
                    if (div_cnt[0]) begin
                        next_div = ~div_clk_out;
                    end
                end
            end
        endcase
    end

    // register counters and clock levels
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt          <= 3'h0;
            ext_q        <= 1'b0;
            div_cnt      <= 2'h0;
            tick         <= 1'b0;
            full_clk_out <= 1'b0;
            div_clk_out  <= 1'b0;
        end else begin
            cnt          <= next_cnt;
            ext_q        <= next_ext_q;
            div_cnt      <= next_div_cnt;
            tick         <= next_tick;
            full_clk_out <= next_full;
            div_clk_out  <= next_div;
        end
    end

endmodule : iface_clk_gen

// *** narrow_memory_port.sv ***
// Contract
// - After reset the interface clock source is taken from two strap pins: external clock, core/4 or core/6.
// - The divided output clock runs at the interface clock divided by 1, 2 or 4 as programmed.
// - The full output clock runs at the interface clock rate.
// - In programmable synchronous mode the shared strobe is an address strobe when select is 0, a read enable when 1.
// - The first strobe is the async read enable, the SDRAM column strobe, or the sync address strobe or read enable.
// - The second strobe is the async output enable, the SDRAM row strobe, or the sync output enable.
// - The device answers a hold request with a hold acknowledge output.
// - The device raises a bus request output while it needs the external bus.
// - The device drives a peripheral transfer output for direct transfers between peripherals.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module narrow_memory_port #(
    parameter int DATA_TICKS = nmp_pkg::DATA_TICKS_DEFAULT
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // clocking
    input  wire logic        iface_clk_in,
    input  wire logic [1:0]  narrow_port_addr_strap,
    output logic             full_clk_out,
    output logic             div_clk_out,
    // arbitration
    input  wire logic        hold_req_in,
    output logic             hold_ack_out,
    output logic             bus_req_out,
    // strobes, active low, with the active-high peripheral transfer output and bus output enable
    output logic             strobe_rd_n,
    output logic             strobe_oe_n,
    output logic             strobe_we_n,
    output logic             periph_xfer_out,
    output logic             bus_oe
);
    import nmp_pkg::*;

    // the data phase counter is eight bits wide and counts down to zero
    if (DATA_TICKS < 1 || DATA_TICKS > 255) begin : g_ticks_check
        $error("DATA_TICKS must be 1..255");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_HOLD = 2'b11
    } acc_state_t;

    // a register write lands at one offset when taken with byte lane 0 enabled
    function automatic logic reg_wr_hit(input logic       go,
                                        input logic       wr,
                                        input logic [3:0] addr,
                                        input logic       lane0,
                                        input logic [3:0] ofs);
        return go & wr & (addr == ofs) & lane0;
    endfunction : reg_wr_hit

    strobe_if sif ();

    // configuration and strap state
    logic       strap_done, next_strap_done;
    clk_src_t   clk_src, next_clk_src;
    mem_type_t  mem_type, next_mem_type;
    logic       rsel, next_rsel;
    ratio_t     ratio, next_ratio;
    logic       pxfer_en, next_pxfer_en;
    // bus slave state
    logic        next_waitrequest;
    logic [31:0] next_readdata;
    logic        bus_go;
    logic        ctrl_wr, access_wr;
    logic        busy;
    // access state
    acc_state_t  state, next_state;
    logic [7:0]  tick_cnt, next_tick_cnt;
    logic        pending, next_pending;
    logic        pend_write, next_pend_write;
    logic        cur_write, next_cur_write;
    logic        next_hold_ack, next_bus_req, next_pxfer, next_bus_oe;
    logic        next_rd_n, next_oe_n, next_we_n;
    logic        tick;

    // interface clock and its two output clocks
    iface_clk_gen u_clk (
        .core_clk     (core_clk),
        .rst          (rst),
        .run          (strap_done),
        .src          (clk_src),
        .ratio        (ratio),
        .iface_clk_in (iface_clk_in),
        .tick         (tick),
        .full_clk_out (full_clk_out),
        .div_clk_out  (div_clk_out)
    );

    // strobe role selection
    strobe_mux u_mux (
        .sif (sif)
    );

    assign sif.mem_type       = mem_type;
    assign sif.read_en_select = rsel;
    assign sif.addr_phase     = (state == ST_ADDR);
    assign sif.data_phase     = (state == ST_DATA);
    assign sif.is_write       = cur_write;

    // a request is taken in the cycle waitrequest is low
    assign bus_go = (avs_read | avs_write) & ~avs_waitrequest;

    // write strobes for the two writable registers
    assign ctrl_wr   = reg_wr_hit(bus_go, avs_write, avs_address, avs_byteenable[0], CTRL_OFS);
    assign access_wr = reg_wr_hit(bus_go, avs_write, avs_address, avs_byteenable[0], ACCESS_OFS);

    // an access owns the bus in its address or data phase
    assign busy = (state == ST_ADDR) | (state == ST_DATA);

    // strap capture and register writes
    always_comb begin
        next_strap_done = 1'b1;
        next_clk_src    = clk_src;
        next_mem_type   = mem_type;
        next_rsel       = rsel;
        next_ratio      = ratio;
        next_pxfer_en   = pxfer_en;
        if (!strap_done) begin
            next_clk_src = strap_to_src(narrow_port_addr_strap);
        end
        if (ctrl_wr) begin
            if (avs_writedata[CTRL_TYPE_LSB +: 2] != 2'b11) begin
                next_mem_type = mem_type_t'(avs_writedata[CTRL_TYPE_LSB +: 2]);
            end
            next_rsel = avs_writedata[CTRL_RSEL_BIT];
            if (avs_writedata[CTRL_RATIO_LSB +: 2] != 2'b11) begin
                next_ratio = ratio_t'(avs_writedata[CTRL_RATIO_LSB +: 2]);
            end
            next_pxfer_en = avs_writedata[CTRL_PXFER_BIT];
        end
    end

    // strap and control register state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_done <= 1'b0;
            clk_src    <= SRC_EXT;
            mem_type   <= mem_type_t'(CTRL_RESET[CTRL_TYPE_LSB +: 2]);
            rsel       <= CTRL_RESET[CTRL_RSEL_BIT];
            ratio      <= ratio_t'(CTRL_RESET[CTRL_RATIO_LSB +: 2]);
            pxfer_en   <= CTRL_RESET[CTRL_PXFER_BIT];
        end else begin
            strap_done <= next_strap_done;
            clk_src    <= next_clk_src;
            mem_type   <= next_mem_type;
            rsel       <= next_rsel;
            ratio      <= next_ratio;
            pxfer_en   <= next_pxfer_en;
        end
    end

    // waitrequest drops for one cycle per request; read data ready then
    always_comb begin
        next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
        next_readdata    = 32'h0000_0000;
        if (avs_address == CTRL_OFS) begin
            next_readdata[CTRL_TYPE_LSB +: 2]  = mem_type;
            next_readdata[CTRL_RSEL_BIT]       = rsel;
            next_readdata[CTRL_RATIO_LSB +: 2] = ratio;
            next_readdata[CTRL_PXFER_BIT]      = pxfer_en;
        end else if (avs_address == ACCESS_OFS) begin
            next_readdata[ACC_START_BIT] = pending;
            next_readdata[ACC_WRITE_BIT] = pend_write;
        end else if (avs_address == STATUS_OFS) begin
            next_readdata[STAT_SRC_LSB +: 2] = clk_src;
            next_readdata[STAT_HOLD_BIT]     = hold_ack_out;
            next_readdata[STAT_BUSY_BIT]     = busy;
            next_readdata[STAT_PEND_BIT]     = pending;
        end
    end

    // bus answer registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // access sequencer and hold arbitration, stepping on interface clock ticks
    always_comb begin
        next_state      = state;
        next_tick_cnt   = tick_cnt;
        next_pending    = pending;
        next_pend_write = pend_write;
        next_cur_write  = cur_write;
        if (tick) begin
            case (state)
                ST_IDLE: begin
                    if (hold_req_in) begin
                        next_state = ST_HOLD;
                    end else if (pending) begin
                        next_state     = ST_ADDR;
                        next_cur_write = pend_write;
                        next_pending   = 1'b0;
                    end
                end
                ST_ADDR: begin
                    next_state    = ST_DATA;
                    next_tick_cnt = 8'(DATA_TICKS - 1);
                end
                ST_DATA: begin
                    if (tick_cnt == 8'h00) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_tick_cnt = tick_cnt - 8'h01;
                    end
                end
                default: begin
                    if (!hold_req_in) begin
                        next_state = ST_IDLE;
                    end
                end
            endcase
        end
        // a start is taken only while no access is pending
        if (access_wr && avs_writedata[ACC_START_BIT] && !pending) begin
            next_pending    = 1'b1;
            next_pend_write = avs_writedata[ACC_WRITE_BIT];
        end
    end

    // registered pin outputs
    always_comb begin
        next_hold_ack = (next_state == ST_HOLD);
        next_bus_req  = next_pending | (next_state == ST_ADDR)
                        | (next_state == ST_DATA);
        next_bus_oe   = (next_state != ST_HOLD);
        next_pxfer    = pxfer_en & (state == ST_DATA) & (next_state == ST_DATA);
        next_rd_n     = sif.rd_n;
        next_oe_n     = sif.oe_n;
        next_we_n     = sif.we_n;
    end

    // sequencer state and registered pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state           <= ST_IDLE;
            tick_cnt        <= 8'h00;
            pending         <= 1'b0;
            pend_write      <= 1'b0;
            cur_write       <= 1'b0;
            hold_ack_out    <= 1'b0;
            bus_req_out     <= 1'b0;
            bus_oe          <= 1'b1;
            periph_xfer_out <= 1'b0;
            strobe_rd_n     <= 1'b1;
            strobe_oe_n     <= 1'b1;
            strobe_we_n     <= 1'b1;
        end else begin
            state           <= next_state;
            tick_cnt        <= next_tick_cnt;
            pending         <= next_pending;
            pend_write      <= next_pend_write;
            cur_write       <= next_cur_write;
            hold_ack_out    <= next_hold_ack;
            bus_req_out     <= next_bus_req;
            bus_oe          <= next_bus_oe;
            periph_xfer_out <= next_pxfer;
            strobe_rd_n     <= next_rd_n;
            strobe_oe_n     <= next_oe_n;
            strobe_we_n     <= next_we_n;
        end
    end

endmodule : narrow_memory_port

// *** narrow_memory_port_asserts.sv ***
`timescale 1ns/100ps
module narrow_memory_port_checker (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // register bus
    input  wire logic avs_read,
    input  wire logic avs_write,
    input  wire logic avs_waitrequest,
    // clocks, arbitration and strobes
    input  wire logic full_clk_out,
    input  wire logic div_clk_out,
    input  wire logic hold_req_in,
    input  wire logic hold_ack_out,
    input  wire logic bus_req_out,
    input  wire logic strobe_rd_n,
    input  wire logic strobe_oe_n,
    input  wire logic strobe_we_n,
    input  wire logic periph_xfer_out,
    input  wire logic bus_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // arbitration with the outside host
    a_held_floats: assert property (hold_ack_out |-> !bus_oe)
        else $error("bus driven during hold");
    a_held_quiet: assert property (hold_ack_out |-> strobe_rd_n && strobe_oe_n && strobe_we_n)
        else $error("strobe active during hold");
    a_ack_cause: assert property ($rose(hold_ack_out) |-> $past(hold_req_in))
        else $error("ack without request");
    a_ack_answer: assert property ($rose(hold_req_in) |-> ##[1:100] (hold_ack_out || !hold_req_in))
        else $error("hold request not answered");
    a_ack_release: assert property ($fell(hold_req_in) |-> ##[1:30] !hold_ack_out)
        else $error("ack kept after request dropped");
    // access activity against bus request
    a_write_owned: assert property (!strobe_we_n |-> bus_req_out || $past(bus_req_out))
        else $error("write strobe outside access");
    a_periph_phase: assert property (periph_xfer_out |-> bus_oe && (bus_req_out || $past(bus_req_out)))
        else $error("transfer output outside access");
    // output clock shapes
    a_full_hold: assert property ($rose(full_clk_out) |=> full_clk_out)
        else $error("full clock high too short");
    a_div_hold: assert property ($changed(div_clk_out) |=> $stable(div_clk_out))
        else $error("divided clock phase too short");
    // register bus handshake
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    // main scenarios
    c_hold: cover property ($rose(hold_ack_out));
    c_write: cover property (!strobe_we_n);
    c_periph: cover property (periph_xfer_out);
endmodule : narrow_memory_port_checker

bind narrow_memory_port narrow_memory_port_checker i_narrow_memory_port_checker (
    .core_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .full_clk_out, .div_clk_out,
    .hold_req_in, .hold_ack_out, .bus_req_out, .strobe_rd_n, .strobe_oe_n, .strobe_we_n,
    .periph_xfer_out, .bus_oe
);

// *** nmp_pkg.sv ***
package nmp_pkg;

    // register byte offsets
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] ACCESS_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;

    // control register fields
    localparam int CTRL_TYPE_LSB  = 0;
    localparam int CTRL_RSEL_BIT  = 2;
    localparam int CTRL_RATIO_LSB = 3;
    localparam int CTRL_PXFER_BIT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // access register fields
    localparam int ACC_START_BIT = 0;
    localparam int ACC_WRITE_BIT = 1;

    // status register fields
    localparam int STAT_SRC_LSB  = 0;
    localparam int STAT_HOLD_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_PEND_BIT = 4;

    // divider periods in core cycles
    localparam logic [2:0] DIV4_PERIOD = 3'h4;
    localparam logic [2:0] DIV6_PERIOD = 3'h6;

    // data phase length in interface clock periods
    localparam int DATA_TICKS_DEFAULT = 2;

    typedef enum logic [1:0] {
        SRC_EXT  = 2'b00,
        SRC_DIV4 = 2'b01,
        SRC_DIV6 = 2'b10
    } clk_src_t;

    typedef enum logic [1:0] {
        MEM_ASYNC = 2'b00,
        MEM_SDRAM = 2'b01,
        MEM_SYNC  = 2'b10
    } mem_type_t;

    typedef enum logic [1:0] {
        RATIO_1 = 2'b00,
        RATIO_2 = 2'b01,
        RATIO_4 = 2'b10
    } ratio_t;

    // strap pins to clock source; the unused code falls back to the external clock
    function automatic clk_src_t strap_to_src(input logic [1:0] strap);
        clk_src_t src;
        src = SRC_EXT;
        if (strap == 2'b01) begin
            src = SRC_DIV4;
        end else if (strap == 2'b10) begin
            src = SRC_DIV6;
        end
        return src;
    endfunction : strap_to_src

endpackage : nmp_pkg

// *** strobe_if.sv ***
`timescale 1ns/100ps
interface strobe_if;
    import nmp_pkg::*;
    mem_type_t mem_type;
    logic      read_en_select;
    logic      addr_phase;
    logic      data_phase;
    logic      is_write;
    logic      rd_n;
    logic      oe_n;
    logic      we_n;

    modport ctrl (output mem_type, output read_en_select, output addr_phase,
                  output data_phase, output is_write, input rd_n, input oe_n, input we_n);
    modport mux  (input mem_type, input read_en_select, input addr_phase,
                  input data_phase, input is_write, output rd_n, output oe_n, output we_n);
endinterface : strobe_if

// *** strobe_mux.sv ***
`timescale 1ns/100ps
module strobe_mux (
    // phase and mode in, active-low strobes out
    strobe_if.mux sif
);
    import nmp_pkg::*;

    logic rd_phase;

    // pin roles per memory type; all strobes active low
    always_comb begin
        rd_phase = sif.data_phase & ~sif.is_write;
        sif.rd_n = 1'b1;
        sif.oe_n = 1'b1;
        sif.we_n = 1'b1;
        case (sif.mem_type)
            MEM_SDRAM: begin
                sif.oe_n = ~sif.addr_phase;
                sif.rd_n = ~sif.data_phase;
                sif.we_n = ~(sif.data_phase & sif.is_write);
            end
            MEM_SYNC: begin
                if (sif.read_en_select) begin
                    sif.rd_n = ~rd_phase;
                end else begin
                    sif.rd_n = ~sif.addr_phase;
                end
                sif.oe_n = ~rd_phase;
                sif.we_n = ~(sif.data_phase & sif.is_write);
            end
            default: begin
                sif.rd_n = ~rd_phase;
                sif.oe_n = ~rd_phase;
                sif.we_n = ~(sif.data_phase & sif.is_write);
            end
        endcase
    end

endmodule : strobe_mux

// *** test_narrow_memory_port.sv ***
`timescale 1ns/100ps
module test_narrow_memory_port;
    import nmp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [1:0]  strap = 2'b01;
    logic        want = 1'b0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, iface_clk_in, full_clk_out, div_clk_out, hold_req_in, hold_ack_out;
    logic        bus_req_out, strobe_rd_n, strobe_oe_n, strobe_we_n, periph_xfer_out, bus_oe;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    narrow_memory_port #(.DATA_TICKS(2)) i_narrow_memory_port (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .iface_clk_in, .narrow_port_addr_strap(strap),
        .full_clk_out, .div_clk_out, .hold_req_in, .hold_ack_out, .bus_req_out,
        .strobe_rd_n, .strobe_oe_n, .strobe_we_n, .periph_xfer_out, .bus_oe);
    host_model i_host_model (.core_clk, .rst, .want, .hold_req_in, .iface_clk_in);

    // clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("[ERR] %0t timeout", $time);
            close_out();
        end
    end

    task chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk

    // one avalon cycle, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= ~w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task do_reset(input logic [1:0] s);
        @(posedge core_clk);
        strap <= s;
        rst   <= 1'b1;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
    endtask : do_reset

    // cycles between two rises, after skipping one period
    task period(input logic which, output int p);
        logic prev, cur;
        cur = 1'b1;
        for (int k = 0; k < 3; k++) begin
            p = 0;
            do begin
                prev = cur;
                @(posedge core_clk);
                cur = which ? div_clk_out : full_clk_out;
                p++;
            end while (!(cur === 1'b1 && prev === 1'b0));
        end
    endtask : period

    task t_clocks;
        logic [1:0] st [4] = '{2'b01, 2'b10, 2'b00, 2'b11};
        logic [1:0] src [4] = '{2'b01, 2'b10, 2'b00, 2'b00};
        int         per [4] = '{4, 6, 10, 10};
        int         p;
        for (int i = 0; i < 4; i++) begin
            do_reset(st[i]);
            bus(1'b0, CTRL_OFS, 32'h0);
            chk(rd === CTRL_RESET, "control reset value");
            bus(1'b0, STATUS_OFS, 32'h0);
            chk(rd[1:0] === src[i], "clock source");
            period(1'b0, p);
            chk(p == per[i], "full clock period");
            for (int r = 0; r < 3; r++) begin
                bus(1'b1, CTRL_OFS, 32'(r) << CTRL_RATIO_LSB);
                period(1'b1, p);
                chk(p == (per[i] << r), "divided clock period");
            end
        end
        bus(1'b1, CTRL_OFS, 32'h18);
        avs_byteenable <= 4'he;
        bus(1'b1, CTRL_OFS, 32'h0);
        avs_byteenable <= 4'hf;
        bus(1'b1, 4'hc, 32'hffff_ffff);
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd === 32'h10, "ratio code 3 or masked write taken");
        bus(1'b0, 4'hc, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        do_reset(2'b01);
    endtask : t_clocks

    // run one access; seen = {periph, we, oe, rd} ever active
    task access(input logic [31:0] ctrl, input logic w, output logic [3:0] seen);
        logic busy;
        int   k;
        bus(1'b1, CTRL_OFS, ctrl);
        bus(1'b1, ACCESS_OFS, {30'h0, w, 1'b1});
        seen = 4'h0;
        busy = 1'b0;
        for (k = 0; k < 100; k++) begin
            @(posedge core_clk);
            seen |= {periph_xfer_out, ~strobe_we_n, ~strobe_oe_n, ~strobe_rd_n};
            if (bus_req_out === 1'b1) busy = 1'b1;
            else if (busy) break;
        end
        chk(busy && k < 100, "bus request around access");
    endtask : access

    task t_access;
        logic [31:0] c [8] = '{32'h20, 32'h00, 32'h01, 32'h01, 32'h02, 32'h02, 32'h06, 32'h06};
        logic [3:0]  e [8] = '{4'hb, 4'h4, 4'h3, 4'h7, 4'h3, 4'h5, 4'h3, 4'h4};
        logic [3:0]  m [8] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
        logic [3:0]  s;
        for (int i = 0; i < 8; i++) begin
            access(c[i], i[0], s);
            chk((s & m[i]) === (e[i] & m[i]), "strobe roles");
        end
    endtask : t_access

    task wait_ack(input logic lvl, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (hold_ack_out !== lvl && k < 80);
    endtask : wait_ack

    task t_hold;
        int k;
        bus(1'b1, CTRL_OFS, 32'h20);
        want <= 1'b1;
        wait_ack(1'b1, k);
        chk(k < 80 && bus_oe === 1'b0, "hold granted and bus floats");
        bus(1'b1, ACCESS_OFS, 32'h1);
        repeat (20) @(posedge core_clk);
        chk(bus_req_out === 1'b1 && strobe_oe_n === 1'b1, "access waits while held");
        bus(1'b0, STATUS_OFS, 32'h0);
        chk({rd[STAT_PEND_BIT], rd[STAT_BUSY_BIT], rd[STAT_HOLD_BIT]} === 3'b101, "status while held");
        bus(1'b0, ACCESS_OFS, 32'h0);
        chk(rd === 32'h1, "pending read access shown");
        want <= 1'b0;
        wait_ack(1'b0, k);
        chk(k < 80 && bus_oe === 1'b1, "hold released");
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (bus_req_out !== 1'b0 && k < 80);
        chk(k < 80, "held access finishes");
        bus(1'b1, ACCESS_OFS, 32'h1);
        repeat (6) @(posedge core_clk);
        want <= 1'b1;
        wait_ack(1'b1, k);
        chk(k < 80 && bus_req_out === 1'b0, "ack only after access");
        want <= 1'b0;
        wait_ack(1'b0, k);
    endtask : t_hold

    // main sequence
    initial begin
        t_clocks();
        t_access();
        t_hold();
        close_out();
    end

    task close_out;
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
endmodule : test_narrow_memory_port
